// >>> verilog/rf_sleep_power_control_defs.vh
`ifndef RF_SLEEP_POWER_CONTROL_DEFS_VH
`define RF_SLEEP_POWER_CONTROL_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices (command port addresses)
// ----------------------------------------------------------------------------
`define ADDR_TRANSMIT_POWER_SELECT       3'h0
`define ADDR_CHANNEL_CLEAR_LEVEL         3'h1
`define ADDR_SLEEP_MODE_CHOICE           3'h2
`define ADDR_SLEEP_OPTION_BITS           3'h3
`define ADDR_INACTIVITY_TIMEOUT          3'h4
`define ADDR_CYCLIC_SLEEP_PERIOD         3'h5
`define ADDR_UNASSOCIATED_SLEEP_PERIOD   3'h6
`define ADDR_STATUS                      3'h7

// ----------------------------------------------------------------------------
// Reset values and legal ranges
// ----------------------------------------------------------------------------
`define RST_TRANSMIT_POWER    8'h04
`define MAX_TRANSMIT_POWER    8'h04
`define RST_CHANNEL_CLEAR     8'h2C
`define MIN_CHANNEL_CLEAR     8'h24
`define MAX_CHANNEL_CLEAR     8'h50
`define RST_SLEEP_MODE        8'h00
`define MAX_SLEEP_MODE        8'h06
`define RST_SLEEP_OPTIONS     8'h00
`define MASK_SLEEP_OPTIONS    8'h03
`define RST_INACTIVITY        16'h1388
`define MIN_INACTIVITY        16'h0001
`define RST_CYCLIC_PERIOD     16'h0000
`define MAX_SLEEP_PERIOD      16'h68B0
`define RST_UNASSOC_PERIOD    16'h03E8
`define MIN_UNASSOC_PERIOD    16'h0001

// ----------------------------------------------------------------------------
// Field positions and mode codes
// ----------------------------------------------------------------------------
`define OPT_NO_WAKE_POLL      0
`define OPT_NO_WAKE_SAMPLE    1
`define MODE_NO_SLEEP         8'h00
`define MODE_PIN_HIBERNATE    8'h01
`define MODE_PIN_DOZE         8'h02
`define MODE_CYCLIC_REMOTE    8'h04
`define MODE_CYCLIC_PIN       8'h05
`define MODE_LEGACY_COORD     8'h06

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLOCK_HZ              10000000
`define TICK_MS               1
`define CYCLES_PER_MS         ((`CLOCK_HZ / 1000) * `TICK_MS)
`define MS_PER_PERIOD_UNIT    10

`endif

// >>> verilog/rf_sleep_power_control.v
// Function
// - Power selector takes codes 0 to 4, five rising levels, resets to 4.
// - Do a clear channel check before each packet; block it on high energy.
// - Threshold is negative dBm, legal 0x24 to 0x50, resets to 0x2C.
// - Sleep mode codes: none, hibernate, doze, reserved, cyclic, cyclic+pin, coordinator.
// - Mode zero keeps the device idle and always ready to receive.
// - Option bit 0 set skips the data poll after a cyclic wake.
// - Option bit 1 set skips the automatic sample on wake.
// - Sleep after inactivity timeout milliseconds of silence; legal 1 to 0xFFFF.
// - Inactivity timeout only applies in cyclic modes 4 and 5.
// - Cyclic sleeper sleeps period times 10 ms, wakes, checks, sleeps again.
// - Coordinator drops held message after 2.5 sleep periods unretrieved.
// - Coordinator with zero period sends messages directly.
// - Unassociated sleeper sleeps its own period before retrying association.
`timescale 1ns/1ps
`default_nettype none
`include "rf_sleep_power_control_defs.vh"

module rf_sleep_power_control #(
  parameter CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input  wire        sys_clk_i,
  input  wire        rstn_i,
  input  wire        cfg_wr_i,
  input  wire [2:0]  cfg_addr_i,
  input  wire [15:0] cfg_wdata_i,
  output reg  [15:0] cfg_rdata_o,
  output wire        cfg_err_o,
  input  wire        activity_i,
  input  wire        is_coordinator_i,
  input  wire        associated_i,
  input  wire        assoc_enabled_i,
  input  wire        wake_pin_i,
  input  wire        tx_request_i,
  input  wire [7:0]  channel_energy_i,
  output wire        tx_grant_o,
  output wire        tx_blocked_o,
  output wire [2:0]  power_code_o,
  input  wire        msg_hold_i,
  input  wire        msg_retrieved_i,
  output wire        send_direct_o,
  output reg         msg_discard_o,
  output wire        asleep_o,
  output reg         wake_poll_o,
  output reg         wake_sample_o,
  output reg         assoc_retry_o
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [2:0] ST_AWAKE = 3'b001;
  localparam [2:0] ST_CYCLE = 3'b010;
  localparam [2:0] ST_UNASC = 3'b100;

  // --------------------------------------------------------------------------
  // Tick limits, cut to the width of their counters
  // --------------------------------------------------------------------------
  localparam integer PRESCALE_LAST_I = CYCLES_PER_MS - 1;
  localparam integer TENTH_LAST_I    = `MS_PER_PERIOD_UNIT - 1;
  localparam [15:0]  PRESCALE_LAST   = PRESCALE_LAST_I[15:0];  // Divider holds at most 65536 cycles per ms
  localparam [3:0]   TENTH_LAST      = TENTH_LAST_I[3:0];

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [7:0]  transmit_power_select_reg;
  reg  [7:0]  channel_clear_level_reg;
  reg  [7:0]  sleep_mode_choice_reg;
  reg  [7:0]  sleep_option_bits_reg;
  reg  [15:0] inactivity_timeout_reg;
  reg  [15:0] cyclic_sleep_period_reg;
  reg  [15:0] unassociated_sleep_period_reg;
  reg  [2:0]  state_reg;
  reg  [15:0] prescale_reg;
  reg  [3:0]  tenth_reg;
  reg  [15:0] idle_ms_reg;
  reg  [15:0] sleep_cnt_reg;
  reg  [17:0] hold_cnt_reg;
  reg         hold_reg;
  reg  [1:0]  wake_sync_reg;
  reg  [1:0]  act_sync_reg;
  reg         cfg_err_reg;

  wire        ms_tick  = (prescale_reg == PRESCALE_LAST);
  wire        ten_tick = ms_tick && (tenth_reg == TENTH_LAST);
  wire        act      = act_sync_reg[1];
  wire        wake_pin = wake_sync_reg[1];

  // True when the mode is one of the two cyclic sleeper codes
  function is_cyclic;
    input [7:0] mode;
    begin
      is_cyclic = (mode == `MODE_CYCLIC_REMOTE) || (mode == `MODE_CYCLIC_PIN);
    end
  endfunction

  // Range check on a write; illegal values are refused and keep the old value
  function legal_write;
    input [2:0]  addr;
    input [15:0] data;
    begin
      case (addr)
        `ADDR_TRANSMIT_POWER_SELECT:     legal_write = data <= {8'h00, `MAX_TRANSMIT_POWER};
        `ADDR_CHANNEL_CLEAR_LEVEL:       legal_write = data >= {8'h00, `MIN_CHANNEL_CLEAR} &&
                                                       data <= {8'h00, `MAX_CHANNEL_CLEAR};
        `ADDR_SLEEP_MODE_CHOICE:         legal_write = data <= {8'h00, `MAX_SLEEP_MODE};
        `ADDR_SLEEP_OPTION_BITS:         legal_write = (data & ~{8'h00, `MASK_SLEEP_OPTIONS}) == 16'h0000;
        `ADDR_INACTIVITY_TIMEOUT:        legal_write = data >= `MIN_INACTIVITY;
        `ADDR_CYCLIC_SLEEP_PERIOD:       legal_write = data <= `MAX_SLEEP_PERIOD;
        `ADDR_UNASSOCIATED_SLEEP_PERIOD: legal_write = data >= `MIN_UNASSOC_PERIOD &&
                                                       data <= `MAX_SLEEP_PERIOD;
        default:                         legal_write = 1'b0;
      endcase
    end
  endfunction

  wire        wr_ok = cfg_wr_i && legal_write(cfg_addr_i, cfg_wdata_i);

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  // Out-of-range writes are dropped so the block never runs on an illegal code
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      transmit_power_select_reg     <= `RST_TRANSMIT_POWER;
      channel_clear_level_reg       <= `RST_CHANNEL_CLEAR;
      sleep_mode_choice_reg         <= `RST_SLEEP_MODE;
      sleep_option_bits_reg         <= `RST_SLEEP_OPTIONS;
      inactivity_timeout_reg        <= `RST_INACTIVITY;
      cyclic_sleep_period_reg       <= `RST_CYCLIC_PERIOD;
      unassociated_sleep_period_reg <= `RST_UNASSOC_PERIOD;
      cfg_err_reg                   <= 1'b0;
    end else begin
      cfg_err_reg <= cfg_wr_i && !wr_ok;
      if (wr_ok) begin
        case (cfg_addr_i)
          `ADDR_TRANSMIT_POWER_SELECT:     transmit_power_select_reg     <= cfg_wdata_i[7:0];
          `ADDR_CHANNEL_CLEAR_LEVEL:       channel_clear_level_reg       <= cfg_wdata_i[7:0];
          `ADDR_SLEEP_MODE_CHOICE:         sleep_mode_choice_reg         <= cfg_wdata_i[7:0];
          `ADDR_SLEEP_OPTION_BITS:         sleep_option_bits_reg         <= cfg_wdata_i[7:0];
          `ADDR_INACTIVITY_TIMEOUT:        inactivity_timeout_reg        <= cfg_wdata_i;
          `ADDR_CYCLIC_SLEEP_PERIOD:       cyclic_sleep_period_reg       <= cfg_wdata_i;
          `ADDR_UNASSOCIATED_SLEEP_PERIOD: unassociated_sleep_period_reg <= cfg_wdata_i;
          default: ;
        endcase
      end
    end
  end

  assign cfg_err_o = cfg_err_reg;

  // Read mux, registered; status word shows the sleep state and held message
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cfg_rdata_o <= 16'h0000;
    end else begin
      case (cfg_addr_i)
        `ADDR_TRANSMIT_POWER_SELECT:     cfg_rdata_o <= {8'h00, transmit_power_select_reg};
        `ADDR_CHANNEL_CLEAR_LEVEL:       cfg_rdata_o <= {8'h00, channel_clear_level_reg};
        `ADDR_SLEEP_MODE_CHOICE:         cfg_rdata_o <= {8'h00, sleep_mode_choice_reg};
        `ADDR_SLEEP_OPTION_BITS:         cfg_rdata_o <= {8'h00, sleep_option_bits_reg};
        `ADDR_INACTIVITY_TIMEOUT:        cfg_rdata_o <= inactivity_timeout_reg;
        `ADDR_CYCLIC_SLEEP_PERIOD:       cfg_rdata_o <= cyclic_sleep_period_reg;
        `ADDR_UNASSOCIATED_SLEEP_PERIOD: cfg_rdata_o <= unassociated_sleep_period_reg;
        default:                         cfg_rdata_o <= {12'h000, hold_reg, state_reg};
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Transmit gating
  // --------------------------------------------------------------------------
  // Threshold is in -dBm, so a smaller energy code means a stronger channel
  assign tx_blocked_o = tx_request_i && (channel_energy_i < channel_clear_level_reg);
  assign tx_grant_o   = tx_request_i && !tx_blocked_o && (state_reg == ST_AWAKE);
  assign power_code_o = transmit_power_select_reg[2:0];

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      act_sync_reg  <= 2'b00;
      wake_sync_reg <= 2'b00;
    end else begin
      act_sync_reg  <= {act_sync_reg[0], activity_i};
      wake_sync_reg <= {wake_sync_reg[0], wake_pin_i};
    end
  end

  // --------------------------------------------------------------------------
  // Prescaler: 1 ms and 10 ms enables
  // --------------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      prescale_reg <= 16'h0000;
      tenth_reg    <= 4'h0;
    end else if (ms_tick) begin
      prescale_reg <= 16'h0000;
      tenth_reg    <= ten_tick ? 4'h0 : tenth_reg + 4'h1;
    end else begin
      prescale_reg <= prescale_reg + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Sleep state machine
  // --------------------------------------------------------------------------
  wire cyclic     = is_cyclic(sleep_mode_choice_reg) && !is_coordinator_i;
  wire period_end = ten_tick && (sleep_cnt_reg <= 16'h0001);
  wire early_wake = (sleep_mode_choice_reg == `MODE_CYCLIC_PIN) && wake_pin;

  // Idle counter restarts on every event; only cyclic modes act on it
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_reg     <= ST_AWAKE;
      idle_ms_reg   <= 16'h0000;
      sleep_cnt_reg <= 16'h0000;
      wake_poll_o   <= 1'b0;
      wake_sample_o <= 1'b0;
      assoc_retry_o <= 1'b0;
    end else begin
      wake_poll_o   <= 1'b0;
      wake_sample_o <= 1'b0;
      assoc_retry_o <= 1'b0;
      case (state_reg)
        ST_AWAKE: begin
          if (act || !cyclic) begin
            idle_ms_reg <= 16'h0000;
          end else if (ms_tick) begin
            if (idle_ms_reg + 16'h0001 >= inactivity_timeout_reg) begin
              idle_ms_reg <= 16'h0000;
              if (assoc_enabled_i && !associated_i) begin
                state_reg     <= ST_UNASC;
                sleep_cnt_reg <= unassociated_sleep_period_reg;
              end else begin
                state_reg     <= ST_CYCLE;
                sleep_cnt_reg <= cyclic_sleep_period_reg;
              end
            end else begin
              idle_ms_reg <= idle_ms_reg + 16'h0001;
            end
          end
        end
        ST_CYCLE, ST_UNASC: begin
          if (!cyclic) begin
            state_reg <= ST_AWAKE;
          end else if (period_end || early_wake) begin
            state_reg     <= ST_AWAKE;
            wake_poll_o   <= !sleep_option_bits_reg[`OPT_NO_WAKE_POLL] && (state_reg == ST_CYCLE);
            wake_sample_o <= !sleep_option_bits_reg[`OPT_NO_WAKE_SAMPLE];
            assoc_retry_o <= (state_reg == ST_UNASC);
          end else if (ten_tick) begin
            sleep_cnt_reg <= sleep_cnt_reg - 16'h0001;
          end
        end
        default: state_reg <= ST_AWAKE;
      endcase
    end
  end

  assign asleep_o = (state_reg != ST_AWAKE);

  // --------------------------------------------------------------------------
  // Coordinator indirect message hold
  // --------------------------------------------------------------------------
  // Limit is 2.5 periods in 5 ms half units, computed as 5 * period exactly
  wire [17:0] hold_limit = ({2'b00, cyclic_sleep_period_reg} << 2) + {2'b00, cyclic_sleep_period_reg};
  wire        coord      = is_coordinator_i || (sleep_mode_choice_reg == `MODE_LEGACY_COORD);
  assign send_direct_o = coord && (cyclic_sleep_period_reg == 16'h0000);

  // Counts half units (5 ms steps) so the half period is exact
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      hold_reg      <= 1'b0;
      hold_cnt_reg  <= 18'h00000;
      msg_discard_o <= 1'b0;
    end else begin
      msg_discard_o <= 1'b0;
      if (msg_hold_i && coord && !send_direct_o) begin
        hold_reg     <= 1'b1;
        hold_cnt_reg <= 18'h00000;
      end else if (msg_retrieved_i || !coord || send_direct_o) begin
        hold_reg <= 1'b0;
      end else if (hold_reg && ms_tick && (tenth_reg == 4'h4 || tenth_reg == 4'h9)) begin
        if (hold_cnt_reg + 18'h00001 >= hold_limit) begin
          hold_reg      <= 1'b0;
          msg_discard_o <= 1'b1;
        end else begin
          hold_cnt_reg <= hold_cnt_reg + 18'h00001;
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> tb/rf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Host side: issues configuration writes and reads on the command port
// ----------------------------------------------------------------------------
module rf_host_model (
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        err_i,
  output var  logic        wr_o,
  output var  logic [2:0]  addr_o,
  output var  logic [15:0] wdata_o
);
  logic [15:0] guard_silence_time;

  // Idle bus at time zero
  initial begin
    wr_o = 1'b0;
    addr_o = 3'h0;
    wdata_o = 16'h0000;
    guard_silence_time = 16'h0000;
  end

  // One word per write, the same word for coordinator and end devices
  task automatic wr(input logic [2:0] a, input logic [15:0] d, output logic e);
    @(negedge sys_clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge sys_clk_i);
    wr_o = 1'b0;
    wdata_o = ~d; // Released data must not look valid
    e = err_i;
    @(negedge sys_clk_i);
    e = e | err_i;
    // Keep guard time under the timeout, or command mode is lost
    if (a == 3'h4 && d != 16'h0000 && guard_silence_time >= d) guard_silence_time = d - 16'h0001;
  endtask

  // Read data lands one cycle after the index is presented
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(negedge sys_clk_i);
    addr_o = a;
    @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// >>> tb/rf_sleep_power_control_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Port checker with shadow copies of the accepted settings
// ----------------------------------------------------------------------------
module rf_sleep_power_control_assertions (
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        cfg_wr_i,
  input wire logic [2:0]  cfg_addr_i,
  input wire logic [15:0] cfg_wdata_i,
  input wire logic        cfg_err_o,
  input wire logic        is_coordinator_i,
  input wire logic        tx_request_i,
  input wire logic [7:0]  channel_energy_i,
  input wire logic        tx_grant_o,
  input wire logic        tx_blocked_o,
  input wire logic [2:0]  power_code_o,
  input wire logic        send_direct_o,
  input wire logic        msg_discard_o,
  input wire logic        asleep_o,
  input wire logic        wake_poll_o,
  input wire logic        wake_sample_o,
  input wire logic        assoc_retry_o
);
  logic [7:0]  thr_q;
  logic [7:0]  mode_q;
  logic [7:0]  opt_q;
  logic [2:0]  pw_q;
  logic [15:0] per_q;
  logic [7:0]  d8;
  logic        coord;
  assign d8 = cfg_wdata_i[7:0];
  assign coord = is_coordinator_i || mode_q == 8'h06;

  // Shadow writes that pass a low-byte range check (index 5 checks all 16 bits), so refused ones must leave outputs alone
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      thr_q <= 8'h2C;
      mode_q <= 8'h00;
      opt_q <= 8'h00;
      pw_q <= 3'h4;
      per_q <= 16'h0000;
    end else if (cfg_wr_i) begin
      case (cfg_addr_i)
        3'h0: if (d8 <= 8'h04) pw_q <= d8[2:0];
        3'h1: if (d8 >= 8'h24 && d8 <= 8'h50) thr_q <= d8;
        3'h2: if (d8 <= 8'h06) mode_q <= d8;
        3'h3: if (d8 <= 8'h03) opt_q <= d8;
        3'h5: if (cfg_wdata_i <= 16'h68B0) per_q <= cfg_wdata_i;
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  a_block_on_energy: assert property (tx_blocked_o == (tx_request_i && channel_energy_i < thr_q))
    else $error("blocked flag disagrees with threshold");
  a_grant_when_clear: assert property (tx_grant_o == (tx_request_i && !tx_blocked_o && !asleep_o))
    else $error("grant flag wrong");
  a_power_follows_reg: assert property (power_code_o == pw_q)
    else $error("power code wrong");
  a_direct_send: assert property (mode_q != 8'h06 |-> send_direct_o == (is_coordinator_i && per_q == 16'h0000))
    else $error("direct send flag wrong");
  a_sleep_only_cyclic: assert property ($rose(asleep_o) |-> (mode_q == 8'h04 || mode_q == 8'h05) && !coord)
    else $error("sleep outside cyclic end device");
  a_pulse_at_wake: assert property (wake_poll_o || wake_sample_o || assoc_retry_o |-> $fell(asleep_o))
    else $error("wake pulse without wake");
  a_poll_option: assert property ($fell(asleep_o) |-> wake_poll_o == (!opt_q[0] && !assoc_retry_o))
    else $error("wake poll wrong");
  a_sample_option: assert property ($fell(asleep_o) |-> wake_sample_o == !opt_q[1])
    else $error("wake sample wrong");
  a_discard_single: assert property (msg_discard_o |=> !msg_discard_o)
    else $error("discard longer than one cycle");
  a_discard_needs_hold: assert property (msg_discard_o |-> coord && per_q != 16'h0000)
    else $error("discard without holding coordinator");
  a_err_after_write: assert property (cfg_err_o |-> $past(cfg_wr_i) || $past(cfg_wr_i, 2))
    else $error("error without write");
endmodule

bind rf_sleep_power_control rf_sleep_power_control_assertions u_chk (
  .sys_clk_i, .rstn_i, .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i, .cfg_err_o, .is_coordinator_i,
  .tx_request_i, .channel_energy_i, .tx_grant_o, .tx_blocked_o, .power_code_o, .send_direct_o,
  .msg_discard_o, .asleep_o, .wake_poll_o, .wake_sample_o, .assoc_retry_o
);
`default_nettype wire

// >>> tb/rf_sleep_power_control_test.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Testbench: command port sequences with expected values
// ----------------------------------------------------------------------------
module rf_sleep_power_control_test;
  logic sys_clk_i, rstn_i, cfg_wr_i, cfg_err_o, activity_i, is_coordinator_i, associated_i;
  logic assoc_enabled_i, wake_pin_i, tx_request_i, tx_grant_o, tx_blocked_o, msg_hold_i;
  logic msg_retrieved_i, send_direct_o, msg_discard_o, asleep_o, wake_poll_o, wake_sample_o, assoc_retry_o;
  logic [2:0]  cfg_addr_i, power_code_o;
  logic [15:0] cfg_wdata_i, cfg_rdata_o;
  logic [7:0]  channel_energy_i;
  int          err_total = 0;
  int          samples_checked = 0;
  logic [15:0] rst_v [0:6] = '{16'h0004, 16'h002C, 16'h0000, 16'h0000, 16'h1388, 16'h0000, 16'h03E8};
  // {index, data, refused, read back}
  logic [39:0] tbl [0:18] = '{40'h0_0005_1_0004, 40'h0_0003_0_0003, 40'h1_0023_1_002C, 40'h1_0051_1_002C,
    40'h1_0024_0_0024, 40'h1_0050_0_0050, 40'h2_0007_1_0000, 40'h2_0006_0_0006, 40'h2_0000_0_0000,
    40'h3_0004_1_0000, 40'h3_0003_0_0003, 40'h4_0000_1_1388, 40'h4_FFFF_0_FFFF, 40'h5_68B1_1_0000,
    40'h5_68B0_0_68B0, 40'h6_0000_1_03E8, 40'h6_68B1_1_03E8, 40'h6_0001_0_0001, 40'h7_0005_1_0001};

  // Short millisecond keeps sleep periods to a few hundred cycles
  rf_sleep_power_control #(.CYCLES_PER_MS(10)) u_dut (.sys_clk_i, .rstn_i, .cfg_wr_i, .cfg_addr_i,
    .cfg_wdata_i, .cfg_rdata_o, .cfg_err_o, .activity_i, .is_coordinator_i, .associated_i, .assoc_enabled_i,
    .wake_pin_i, .tx_request_i, .channel_energy_i, .tx_grant_o, .tx_blocked_o, .power_code_o, .msg_hold_i,
    .msg_retrieved_i, .send_direct_o, .msg_discard_o, .asleep_o, .wake_poll_o, .wake_sample_o, .assoc_retry_o);
  rf_host_model u_host (.sys_clk_i, .rdata_i(cfg_rdata_o), .err_i(cfg_err_o), .wr_o(cfg_wr_i),
    .addr_o(cfg_addr_i), .wdata_o(cfg_wdata_i));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    samples_checked++;
    if (n < lo || n > hi) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h..%h", $time, n, lo, hi);
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Waits for sleep, measures its length, then checks the wake pulses
  task automatic sleep_cycle(input int lo, input int hi, input logic [2:0] pulses);
    int n;
    n = 0;
    while (asleep_o !== 1'b1 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    n = 0;
    while (asleep_o === 1'b1 && n < 2000) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk_rng(n, lo, hi);
    chk({13'h0, wake_poll_o, wake_sample_o, assoc_retry_o}, {13'h0, pulses});
  endtask

  // Hold, then either let it time out or retrieve it; count cycles to discard
  task automatic hold_msg(input int retrieve_at, output int n);
    @(negedge sys_clk_i);
    msg_hold_i = 1'b1;
    @(negedge sys_clk_i);
    msg_hold_i = 1'b0;
    n = 0;
    while (msg_discard_o !== 1'b1 && n < 700) begin
      @(negedge sys_clk_i);
      msg_retrieved_i = (n == retrieve_at);
      n++;
    end
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_total++;
    close_out();
  end

  initial begin
    logic e;
    logic [15:0] d;
    int n;
    logic [7:0] modes [0:4];
    modes = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06};
    {rstn_i, is_coordinator_i, associated_i, assoc_enabled_i, wake_pin_i, tx_request_i} = 6'h00;
    {msg_hold_i, msg_retrieved_i} = 2'b00;
    activity_i = 1'b1;
    channel_energy_i = 8'h00;
    repeat (16) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    for (int i = 0; i < 7; i++) begin
      u_host.rd(i[2:0], d);
      chk(d, rst_v[i]);
    end
    for (int i = 0; i < 19; i++) begin
      u_host.wr(tbl[i][38:36], tbl[i][35:20], e);
      chk({15'h0, e}, {15'h0, tbl[i][16]});
      u_host.rd(tbl[i][38:36], d);
      chk(d, tbl[i][15:0]);
    end
    for (int c = 0; c < 5; c++) begin
      u_host.wr(0, c[15:0], e);
      chk({13'h0, power_code_o}, c[15:0]);
    end
    u_host.wr(1, 16'h0030, e);
    tx_request_i = 1'b1;
    channel_energy_i = 8'h2F;
    @(negedge sys_clk_i);
    chk({14'h0, tx_blocked_o, tx_grant_o}, 16'h0002);
    channel_energy_i = 8'h30;
    @(negedge sys_clk_i);
    chk({14'h0, tx_blocked_o, tx_grant_o}, 16'h0001);
    tx_request_i = 1'b0;
    u_host.wr(4, 16'h0002, e);
    activity_i = 1'b0;
    for (int m = 0; m < 5; m++) begin
      u_host.wr(2, {8'h00, modes[m]}, e);
      repeat (100) @(negedge sys_clk_i);
      chk({15'h0, asleep_o}, 16'h0000);
    end
    activity_i = 1'b1;
    associated_i = 1'b1;
    u_host.wr(5, 16'h0003, e);
    u_host.wr(3, 16'h0000, e);
    u_host.wr(2, 16'h0004, e);
    activity_i = 1'b0;
    n = 0;
    while (asleep_o !== 1'b1 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk_rng(n, 8, 35);
    sleep_cycle(195, 305, 3'b110);
    u_host.wr(3, 16'h0003, e);
    sleep_cycle(195, 305, 3'b000);
    activity_i = 1'b1;
    repeat (60) @(negedge sys_clk_i);
    chk({15'h0, asleep_o}, 16'h0000);
    associated_i = 1'b0;
    assoc_enabled_i = 1'b1;
    u_host.wr(6, 16'h0001, e);
    activity_i = 1'b0;
    sleep_cycle(5, 105, 3'b001);
    // Pin wakeup mode: sleep, refuse a send while asleep, then wake early by pin
    associated_i = 1'b1;
    u_host.wr(3, 16'h0000, e);
    u_host.wr(2, 16'h0005, e);
    n = 0;
    while (asleep_o !== 1'b1 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    repeat (20) @(negedge sys_clk_i);
    tx_request_i = 1'b1;
    @(negedge sys_clk_i);
    chk({14'h0, tx_blocked_o, tx_grant_o}, 16'h0000);
    tx_request_i = 1'b0;
    wake_pin_i = 1'b1;
    n = 0;
    while (asleep_o === 1'b1 && n < 20) begin
      @(negedge sys_clk_i);
      n++;
    end
    wake_pin_i = 1'b0;
    chk_rng(n, 3, 3);
    chk({13'h0, wake_poll_o, wake_sample_o, assoc_retry_o}, 16'h0006);
    activity_i = 1'b1;
    is_coordinator_i = 1'b1;
    u_host.wr(2, 16'h0000, e);
    u_host.wr(5, 16'h0002, e);
    chk({15'h0, send_direct_o}, 16'h0000);
    hold_msg(-1, n);
    chk_rng(n, 440, 510);
    hold_msg(100, n);
    chk_rng(n, 700, 700);
    u_host.wr(5, 16'h0000, e);
    chk({15'h0, send_direct_o}, 16'h0001);
    close_out();
  end
endmodule
`default_nettype wire
